// ### hdl/msicp_pkg.sv
// Package for the message signaled interrupt capability port.
// Assumes a 32-bit AXI4-Lite register bus and a single clock domain.
package msicp_pkg;

    localparam logic [11:0] MSICP_OFS_CONTROL   = 12'h0d0;
    localparam logic [11:0] MSICP_OFS_LOWER     = 12'h0d4;
    localparam logic [11:0] MSICP_OFS_UPPER     = 12'h0d8;
    localparam logic [11:0] MSICP_OFS_PAYLOAD   = 12'h0dc;
    localparam logic [11:0] MSICP_OFS_EVENT     = 12'h0e0;

    localparam logic [7:0]  MSICP_CAP_ID        = 8'h05;
    localparam logic [7:0]  MSICP_NEXT_PTR_RST  = 8'h00;
    localparam logic [2:0]  MSICP_REQ_COUNT     = 3'h0;
    localparam logic [2:0]  MSICP_ALLOC_RST     = 3'h0;
    localparam logic        MSICP_WIDE_CAPABLE  = 1'h1;
    localparam logic [31:0] MSICP_ADDR_RST      = 32'h00000000;
    localparam logic [15:0] MSICP_PAYLOAD_RST   = 16'h0000;

    localparam int MSICP_ID_LO      = 0;
    localparam int MSICP_NXT_LO     = 8;
    localparam int MSICP_EN_BIT     = 16;
    localparam int MSICP_REQ_LO     = 17;
    localparam int MSICP_ALLOC_LO   = 20;
    localparam int MSICP_WIDE_BIT   = 23;

    localparam logic [1:0] MSICP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] MSICP_RESP_SLVERR = 2'h2;

    // One posted memory write towards the root
    typedef struct packed {
        logic [63:0] address;
        logic        wide;
        logic [31:0] data;
    } msicp_msg_t;

endpackage

// ### hdl/msicp_port.sv
// Message signaled interrupt capability port with AXI4-Lite register access.
// Assumes the upstream request path accepts one message with msgValid/msgReady.
//
// Notes on behaviour
// [RULE1] Capability identifier bits 7:0 read-only, value 0x5.
// [RULE2] Next pointer bits 15:8 reset 0x0, writable only when lock is open.
// [RULE3] Enable bit 16 resets zero; no messages sent while it is zero.
// [RULE4] Requested message count bits 19:17 read-only zero.
// [RULE5] Allocated count bits 22:20 reset zero; one message always used.
// [RULE6] Bit 23 reads one (64-bit capable); bits 31:24 read zero.
// [RULE7] Lower address bits 31:2 read/write reset zero; bits 1:0 read zero.
// [RULE8] Nonzero upper address selects 64-bit message address, else 32-bit.
// [RULE9] Payload bits 15:0 read/write; bits 31:16 read zero.
// [RULE10] Software must program addresses that route to the root port.
// [RULE11] Enabled event issues one memory write, payload low, zeros above.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps

module msicp_port
    import msicp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        cfgWriteLock,
    input  wire logic        irqEvent,
    output msicp_msg_t       msgOut,
    output logic             msgValid,
    input  wire logic        msgReady,
    output logic             msgPending,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    logic [7:0]  nextPtr_q;
    logic        enable_q;
    logic [2:0]  allocCount_q;
    logic [29:0] lowerAddr_q;
    logic [31:0] upperAddr_q;
    logic [15:0] payload_q;
    logic [11:0] awAddr_q;
    logic        awHeld_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        wHeld_q;
    logic        bValid_q;
    logic [1:0]  bResp_q;
    logic        rValid_q;
    logic [31:0] rData_q;
    logic [1:0]  rResp_q;
    logic        pend_q;
    msicp_msg_t  msg_q;
    logic        msgValid_q;
    logic        swTrigger;

    // Write channels are taken independently and joined once both are held
    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready  = !wHeld_q && !bValid_q;
    wire         doWrite = awHeld_q && wHeld_q && !bValid_q;
    wire  [11:0] wAddr   = {awAddr_q[11:2], 2'b00};

    wire wrCtrl    = doWrite && (wAddr == MSICP_OFS_CONTROL);
    wire wrLower   = doWrite && (wAddr == MSICP_OFS_LOWER);
    wire wrUpper   = doWrite && (wAddr == MSICP_OFS_UPPER);
    wire wrPayload = doWrite && (wAddr == MSICP_OFS_PAYLOAD);
    wire wrEvent   = doWrite && (wAddr == MSICP_OFS_EVENT);
    wire wrHit     = wrCtrl || wrLower || wrUpper || wrPayload || wrEvent;

    // Byte-lane merge against the current value of each register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    wire [31:0] ctrlWord = {8'h00, MSICP_WIDE_CAPABLE, allocCount_q, MSICP_REQ_COUNT,
                            enable_q, nextPtr_q, MSICP_CAP_ID};          // RULE1 RULE4 RULE6
    wire [31:0] ctrlNew  = merge(ctrlWord, wData_q, wStrb_q);
    wire [31:0] lowNew   = merge({lowerAddr_q, 2'b00}, wData_q, wStrb_q);
    wire [31:0] upNew    = merge(upperAddr_q, wData_q, wStrb_q);
    wire [31:0] payNew   = merge({16'h0000, payload_q}, wData_q, wStrb_q);
    assign swTrigger = wrEvent && wStrb_q[0] && wData_q[0];

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bValid_q <= 1'b0;
            bResp_q  <= MSICP_RESP_OKAY;
        end else if (doWrite) begin
            bValid_q <= 1'b1;
            bResp_q  <= wrHit ? MSICP_RESP_OKAY : MSICP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bValid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp  = bResp_q;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            nextPtr_q    <= MSICP_NEXT_PTR_RST;
            enable_q     <= 1'b0;
            allocCount_q <= MSICP_ALLOC_RST;
        end else if (wrCtrl) begin
            if (!cfgWriteLock) begin
                nextPtr_q <= ctrlNew[MSICP_NXT_LO +: 8];            // RULE2
            end
            enable_q     <= ctrlNew[MSICP_EN_BIT];                   // RULE3
            allocCount_q <= ctrlNew[MSICP_ALLOC_LO +: 3];            // RULE5
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lowerAddr_q <= MSICP_ADDR_RST[31:2];
            upperAddr_q <= MSICP_ADDR_RST;
            payload_q   <= MSICP_PAYLOAD_RST;
        end else begin
            if (wrLower) begin
                lowerAddr_q <= lowNew[31:2];                         // RULE7
            end
            if (wrUpper) begin
                upperAddr_q <= upNew;
            end
            if (wrPayload) begin
                payload_q <= payNew[15:0];                           // RULE9
            end
        end
    end

    // Read path: one registered answer, unmapped offsets give SLVERR and zero
    assign s_axi_arready = !rValid_q;
    wire [11:0] rAddr = {s_axi_araddr[11:2], 2'b00};
    logic [31:0] rSel;
    logic        rHit;
    always_comb begin
        rHit = 1'b1;
        case (rAddr)
            MSICP_OFS_CONTROL: rSel = ctrlWord;
            MSICP_OFS_LOWER:   rSel = {lowerAddr_q, 2'b00};              // RULE7
            MSICP_OFS_UPPER:   rSel = upperAddr_q;
            MSICP_OFS_PAYLOAD: rSel = {16'h0000, payload_q};             // RULE9
            MSICP_OFS_EVENT:   rSel = {31'h00000000, pend_q};
            default: begin
                rSel = 32'h00000000;
                rHit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rValid_q <= 1'b0;
            rData_q  <= 32'h00000000;
            rResp_q  <= MSICP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_q <= 1'b1;
            rData_q  <= rSel;
            rResp_q  <= rHit ? MSICP_RESP_OKAY : MSICP_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rValid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata  = rData_q;
    assign s_axi_rresp  = rResp_q;

    // Events collapse into one pending bit; with a single vector nothing
    // is gained by counting them, and a new event during send re-arms it
    wire eventIn = irqEvent || swTrigger;
    wire launch  = pend_q && enable_q && !msgValid_q;                // RULE3
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pend_q <= 1'b0;
        end else if (eventIn) begin
            pend_q <= 1'b1;
        end else if (launch) begin
            pend_q <= 1'b0;
        end
    end

    // Upper address decides the address form; allocated count never widens
    // the vector, so the payload is sent as programmed
    wire wideAddr = (upperAddr_q != 32'h00000000);                   // RULE8
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            msgValid_q <= 1'b0;
            msg_q      <= '0;
        end else if (launch) begin
            msgValid_q    <= 1'b1;                                   // RULE11
            msg_q.address <= wideAddr ? {upperAddr_q, lowerAddr_q, 2'b00}
                                      : {32'h00000000, lowerAddr_q, 2'b00}; // RULE8 RULE10
            msg_q.wide    <= wideAddr;
            msg_q.data    <= {16'h0000, payload_q};                  // RULE11 RULE5
        end else if (msgReady) begin
            msgValid_q <= 1'b0;
        end
    end
    assign msgValid   = msgValid_q;
    assign msgOut     = msg_q;
    assign msgPending = pend_q;

endmodule

// ### testbench/msicp_port_assertions.sv
// Checker for the interrupt capability port, watching its ports only.
// Assumes one clock domain; bound to every port instance below.
`timescale 1ns/1ps
module msicp_port_assertions
    import msicp_pkg::*;
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        irqEvent,
    input msicp_msg_t       msgOut,
    input wire logic        msgValid,
    input wire logic        msgReady,
    input wire logic        msgPending,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    logic [11:0] rdAddr_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Address of the read in flight, so read data can be judged per register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) rdAddr_q <= 12'h000;
        else if (s_axi_arvalid && s_axi_arready) rdAddr_q <= s_axi_araddr;
    end
    sequence sStall; msgValid && !msgReady; endsequence
    sequence sOffer; msgValid; endsequence
    AST_MSG_HOLD: assert property (sStall |=> msgValid && $stable(msgOut))
        else $error("message changed while stalled");
    AST_DATA_HIGH: assert property (sOffer |-> msgOut.data[31:16] == 16'h0000)
        else $error("message data upper half not zero");
    AST_ALIGN: assert property (sOffer |-> msgOut.address[1:0] == 2'h0)
        else $error("message address not aligned");
    AST_WIDE: assert property (sOffer |-> msgOut.wide == (msgOut.address[63:32] != 32'h0))
        else $error("address width choice wrong");
    AST_EVENT: assert property (irqEvent |=> msgPending || msgValid)
        else $error("event lost");
    AST_CAP_FIXED: assert property (s_axi_rvalid && rdAddr_q == MSICP_OFS_CONTROL |->
        s_axi_rdata[7:0] == 8'h05 && s_axi_rdata[19:17] == 3'h0 && s_axi_rdata[31:23] == 9'h001)
        else $error("fixed control bits wrong");
    AST_LOW_ALIGN: assert property (s_axi_rvalid && rdAddr_q == MSICP_OFS_LOWER |->
        s_axi_rdata[1:0] == 2'h0) else $error("lower address low bits not zero");
    AST_PAY_HIGH: assert property (s_axi_rvalid && rdAddr_q == MSICP_OFS_PAYLOAD |->
        s_axi_rdata[31:16] == 16'h0000) else $error("payload upper bits not zero");
endmodule
bind msicp_port msicp_port_assertions u_chk (.clock, .sys_rst, .irqEvent, .msgOut, .msgValid,
    .msgReady, .msgPending, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rdata);

// ### testbench/msicp_root_model.sv
// Root side model: takes posted interrupt writes and keeps the last one.
// Assumes the port offers one message at a time with msgValid held.
`timescale 1ns/1ps
module msicp_root_model
    import msicp_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic slowMode,
    input msicp_msg_t msgIn,
    input wire logic msgValid,
    output logic     msgReady,
    output msicp_msg_t lastMsg,
    output int       msgCount
);
    logic toggle_q;
    // Slow mode accepts only every other cycle to stall the port
    assign msgReady = msgValid && (!slowMode || toggle_q);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            toggle_q <= 1'b0;
            msgCount <= 0;
            lastMsg  <= '0;
        end else begin
            toggle_q <= ~toggle_q;
            if (msgValid && msgReady) begin
                msgCount <= msgCount + 1;
                lastMsg  <= msgIn;
            end
        end
    end
endmodule

// ### testbench/msicp_port_test.sv
// Self-checking bench for the interrupt capability port.
// Assumes the root model and the bound checker are compiled before it.
`timescale 1ns/1ps
module msicp_port_test
    import msicp_pkg::*;
;
    logic        clock, sys_rst, cfgWriteLock, irqEvent, slowMode, msgValid, msgReady, msgPending;
    msicp_msg_t  msgOut, lastMsg;
    int          msgCount, miscompares = 0, checked = 0, cycles = 0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    msicp_port u_dut (.clock, .sys_rst, .cfgWriteLock, .irqEvent, .msgOut, .msgValid, .msgReady,
        .msgPending, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    msicp_root_model u_root (.clock, .sys_rst, .slowMode, .msgIn(msgOut), .msgValid, .msgReady,
        .lastMsg, .msgCount);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrChk(input logic [11:0] a, input logic [31:0] d,
                         input logic [1:0] er = MSICP_RESP_OKAY);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        while (!s_axi_bvalid) @(posedge clock);
        chk("bresp", er, s_axi_bresp);
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] e,
                         input logic [1:0] er = MSICP_RESP_OKAY);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clock);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        chk("rdata", e, rd);
        chk("rresp", er, rs);
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        // Response readies stay high, so back-to-back calls never toggle them in one step
        {cfgWriteLock, irqEvent, slowMode, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        s_axi_wstrb = 4'hf;
        sys_rst = 1'b1;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        rdChk(MSICP_OFS_CONTROL, 32'h00800005);
        rdChk(MSICP_OFS_LOWER, 32'h0);
        rdChk(MSICP_OFS_UPPER, 32'h0);
        rdChk(MSICP_OFS_PAYLOAD, 32'h0);
        $display("test reset done");
        cfgWriteLock <= 1'b1;
        wrChk(MSICP_OFS_CONTROL, 32'hffffffff);
        rdChk(MSICP_OFS_CONTROL, 32'h00f10005);
        cfgWriteLock <= 1'b0;
        wrChk(MSICP_OFS_CONTROL, 32'h0000ab00);
        rdChk(MSICP_OFS_CONTROL, 32'h0080ab05);
        wrChk(MSICP_OFS_LOWER, 32'hffffffff);
        rdChk(MSICP_OFS_LOWER, 32'hfffffffc);
        wrChk(MSICP_OFS_PAYLOAD, 32'hffffa5c3);
        rdChk(MSICP_OFS_PAYLOAD, 32'h0000a5c3);
        wrChk(MSICP_OFS_UPPER, 32'h00000010);
        rdChk(MSICP_OFS_UPPER, 32'h00000010);
        $display("test fields done");
        slowMode <= 1'b1;
        irqEvent <= 1'b1;
        @(posedge clock);
        irqEvent <= 1'b0;
        repeat (8) @(posedge clock);
        chk("count", 0, msgCount);
        chk("pending", 1, msgPending);
        wrChk(MSICP_OFS_CONTROL, 32'h00310000);
        while (msgCount < 1) @(posedge clock);
        chk("addr64", 64'h00000010_fffffffc, lastMsg.address);
        chk("wide64", 1, lastMsg.wide);
        chk("data", 32'h0000a5c3, lastMsg.data);
        wrChk(MSICP_OFS_UPPER, 32'h0);
        wrChk(MSICP_OFS_LOWER, 32'h80001004);
        slowMode <= 1'b0;
        wrChk(MSICP_OFS_EVENT, 32'h1);
        while (msgCount < 2) @(posedge clock);
        chk("addr32", 64'h80001004, lastMsg.address);
        chk("wide32", 0, lastMsg.wide);
        repeat (8) @(posedge clock);
        chk("msgs", 2, msgCount);
        $display("test message done");
        wrChk(12'h0e4, 32'hffffffff, MSICP_RESP_SLVERR);
        rdChk(12'h0e4, 32'h0, MSICP_RESP_SLVERR);
        rdChk(MSICP_OFS_LOWER, 32'h80001004);
        $display("test decode done");
        stop_test();
    end
endmodule
